// ==== src/ivm_input_voltage_limit_monitor.sv ====
`timescale 1ns/1ps
module ivm_input_voltage_limit_monitor
#(
	parameter logic [7:0] CLEAR_CMD = 8'h03
)
(
	input  wire logic                 CLK_SYS,
	input  wire logic                 RESETN,
	input  wire logic                 CE,
	input  wire ivm_pkg::ivm_cmd_t    CMD,
	input  wire logic                 WRITE_PROTECT,
	input  wire logic [15:0]          VIN,
	input  wire logic [1:0]           UNDERVOLTAGE_LOCKOUT_STRAP_STRAP,
	output logic      [15:0]          RD_DATA,
	output logic                      RD_VALID,
	output logic                      RD_ERR,
	output logic                      WR_REFUSED,
	output ivm_pkg::ivm_status_t      STATUS,
	output logic                      UV_FAULT_ACTIVE,
	output logic                      HOST_NOTIFY
);
	import ivm_pkg::*;

	// ************************************************
	// Declarations
	// ************************************************
	localparam int NCMP = 5;

	ivm_state_t  st;
	ivm_state_t  next_st;
	logic [1:0]  rst_pipe;
	logic        rst_n_s;
	logic [15:0] cmp_a [NCMP];
	logic [15:0] cmp_b [NCMP];
	logic        cmp_gt [NCMP];
	logic        cmp_lt [NCMP];
	logic [15:0] fault_def;
	logic [15:0] warn_def;
	logic        clr;
	logic        lim_code;
	logic        in_range;
	logic        ev_ov;
	logic        ev_uvw;
	logic        uvf_lo;
	logic        uvw_hi;
	logic        uv_next;

	// ************************************************
	// Reset release
	// ************************************************
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rst_pipe <= RST_SYNC_INIT;
		end
		else if (CE)
		begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end

	assign rst_n_s = rst_pipe[1];

	// ************************************************
	// Comparators
	// ************************************************
	always_comb
	begin
		cmp_a[0] = VIN;
		cmp_b[0] = st.ov_lim;
		cmp_a[1] = VIN;
		cmp_b[1] = st.uvw_lim;
		cmp_a[2] = VIN;
		cmp_b[2] = st.uvf_lim;
		cmp_a[3] = CMD.data;
		cmp_b[3] = LIN_MAX_VALUE;
		cmp_a[4] = CMD.data;
		cmp_b[4] = LIN_ZERO;
	end

	for (genvar i = 0; i < NCMP; i++)
	begin : g_cmp
		ivm_lin_cmp u_cmp
		(
			.a  (cmp_a[i]),
			.b  (cmp_b[i]),
			.gt (cmp_gt[i]),
			.lt (cmp_lt[i])
		);
	end

	ivm_strap u_strap
	(
		.strap     (UNDERVOLTAGE_LOCKOUT_STRAP_STRAP),
		.fault_def (fault_def),
		.warn_def  (warn_def)
	);

	// ************************************************
	// Decode and events
	// ************************************************
	always_comb
	begin
		clr      = CMD.wr && (CMD.code == CLEAR_CMD);
		lim_code = (CMD.code == CMD_OV_WARN) || (CMD.code == CMD_UV_WARN)
			|| (CMD.code == CMD_UV_FAULT);
		in_range = !cmp_gt[3] && !cmp_lt[4];
		ev_ov    = (st.fsm == ST_RUN) && cmp_gt[0];
		ev_uvw   = (st.fsm == ST_RUN) && cmp_lt[1];
		uvf_lo   = (st.fsm == ST_RUN) && cmp_lt[2];
		uvw_hi   = cmp_gt[1];
		if (uvf_lo)
		begin
			uv_next = 1'b1;
		end
		else if (uvw_hi)
		begin
			uv_next = 1'b0;
		end
		else
		begin
			uv_next = st.uv_active;
		end
	end

	// ************************************************
	// Next state
	// ************************************************
	always_comb
	begin
		next_st            = st;
		next_st.rd_valid   = 1'b0;
		next_st.rd_err     = 1'b0;
		next_st.wr_refused = 1'b0;
		case (st.fsm)
			ST_LOAD:
			begin
				next_st.ov_lim  = OV_WARN_RESET;
				next_st.uvw_lim = warn_def;
				next_st.uvf_lim = fault_def;
				next_st.fsm     = ST_RUN;
			end
			ST_RUN:
			begin
				if (CMD.wr && !clr)
				begin
					if (!lim_code || WRITE_PROTECT || !in_range)
					begin
						next_st.wr_refused = 1'b1;
					end
					else
					begin
						case (CMD.code)
							CMD_OV_WARN:  next_st.ov_lim = CMD.data;
							CMD_UV_WARN:  next_st.uvw_lim = CMD.data;
							CMD_UV_FAULT: next_st.uvf_lim = CMD.data;
							default:      next_st.wr_refused = 1'b1;
						endcase
					end
				end
				if (CMD.rd)
				begin
					next_st.rd_valid = 1'b1;
					case (CMD.code)
						CMD_OV_WARN:  next_st.rd_data = st.ov_lim;
						CMD_UV_WARN:  next_st.rd_data = st.uvw_lim;
						CMD_UV_FAULT: next_st.rd_data = st.uvf_lim;
						default:
						begin
							next_st.rd_valid = 1'b0;
							next_st.rd_err   = 1'b1;
						end
					endcase
				end
				next_st.uv_active = uv_next;
				next_st.status.ov_warn   = (st.status.ov_warn && !clr) || ev_ov;
				next_st.status.uv_warn   = (st.status.uv_warn && !clr) || ev_uvw;
				next_st.status.uv_fault  = (st.status.uv_fault && !clr) || uv_next;
				next_st.status.other     = (st.status.other && !clr) || ev_ov || ev_uvw
					|| uv_next;
				next_st.status.input_sum = (st.status.input_sum && !clr) || ev_ov || ev_uvw
					|| uv_next;
				next_st.notify           = (st.notify && !clr) || ev_ov || ev_uvw || uv_next;
			end
			default:
			begin
				next_st.fsm = ST_LOAD;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			st <= STATE_RESET;
		end
		else if (CE)
		begin
			st <= next_st;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	assign RD_DATA         = st.rd_data;
	assign RD_VALID        = st.rd_valid;
	assign RD_ERR          = st.rd_err;
	assign WR_REFUSED      = st.wr_refused;
	assign STATUS          = st.status;
	assign UV_FAULT_ACTIVE = st.uv_active;
	assign HOST_NOTIFY     = st.notify;

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!rst_n_s);

	property p_ov_reset;
		rst_n_s && CE && st.fsm == ST_LOAD |=> st.ov_lim == 16'hd360 && st.fsm == ST_RUN;
	endproperty
	a_ov_reset: assert property (p_ov_reset) else $error("ov reset value");

	property p_uv_defaults;
		rst_n_s && CE && st.fsm == ST_LOAD |=> st.uvf_lim == $past(fault_def)
			&& st.uvw_lim == $past(warn_def);
	endproperty
	a_uv_defaults: assert property (p_uv_defaults) else $error("strap defaults");

	property p_warn_factor;
		st.fsm == ST_RUN && $past(st.fsm) == ST_LOAD
			|-> 22'(st.uvw_lim[10:0]) * 22'd10 <= 22'(st.uvf_lim[10:0]) * 22'd11
			&& 22'(st.uvf_lim[10:0]) * 22'd11 < 22'(st.uvw_lim[10:0]) * 22'd10 + 22'd10
			&& st.uvw_lim[15:11] == st.uvf_lim[15:11];
	endproperty
	a_warn_factor: assert property (p_warn_factor) else $error("warn default");

	property p_ov_event;
		CE && st.fsm == ST_RUN && cmp_gt[0]
			|=> st.status.ov_warn && st.status.other && st.status.input_sum && st.notify;
	endproperty
	a_ov_event: assert property (p_ov_event) else $error("ov warning event");

	property p_uvw_event;
		CE && st.fsm == ST_RUN && cmp_lt[1]
			|=> st.status.uv_warn && st.status.other && st.status.input_sum && st.notify;
	endproperty
	a_uvw_event: assert property (p_uvw_event) else $error("uv warning event");

	property p_uv_hold;
		CE && st.uv_active && !cmp_gt[1] |=> st.uv_active;
	endproperty
	a_uv_hold: assert property (p_uv_hold) else $error("uv fault dropped");

	property p_sticky;
		!(CE && clr) |=> (5'(st.status) & 5'($past(st.status))) == 5'($past(st.status))
			&& (st.notify || !$past(st.notify));
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit lost");

	property p_protect;
		CE && st.fsm == ST_RUN && CMD.wr && !clr && WRITE_PROTECT
			|=> WR_REFUSED && $stable(st.ov_lim) && $stable(st.uvw_lim) && $stable(st.uvf_lim);
	endproperty
	a_protect: assert property (p_protect) else $error("protected write taken");

	property p_write;
		CE && st.fsm == ST_RUN && CMD.wr && CMD.code == 8'h57 && !WRITE_PROTECT && in_range
			|=> st.ov_lim == $past(CMD.data) && !WR_REFUSED;
	endproperty
	a_write: assert property (p_write) else $error("threshold write lost");

	property p_range;
		CE && st.fsm == ST_RUN && CMD.wr && lim_code && (cmp_gt[3] || cmp_lt[4])
			|=> WR_REFUSED && $stable(st.ov_lim) && $stable(st.uvw_lim) && $stable(st.uvf_lim);
	endproperty
	a_range: assert property (p_range) else $error("out of range taken");

endmodule : ivm_input_voltage_limit_monitor

// ==== include/ivm_pkg.sv ====
package ivm_pkg;

	// ************************************************
	// Threshold word layout
	// ************************************************
	localparam int LIN_EXP_MSB = 15;
	localparam int LIN_EXP_LSB = 11;
	localparam int LIN_MAN_MSB = 10;
	localparam int LIN_FIX_W   = 48;
	localparam logic [5:0] LIN_FRAC_SHIFT = 6'h10;

	// ************************************************
	// Command codes and values
	// ************************************************
	localparam logic [7:0]  CMD_OV_WARN   = 8'h57;
	localparam logic [7:0]  CMD_UV_WARN   = 8'h58;
	localparam logic [7:0]  CMD_UV_FAULT  = 8'h59;
	localparam logic [15:0] OV_WARN_RESET = 16'hd360;
	localparam logic [15:0] LIN_MAX_VALUE = 16'h0013;
	localparam logic [15:0] LIN_ZERO      = 16'h0000;
	localparam logic [21:0] WARN_NUM      = 22'h00000b;
	localparam logic [21:0] WARN_DEN      = 22'h00000a;
	localparam logic [1:0]  RST_SYNC_INIT = 2'h0;

	// ************************************************
	// Types
	// ************************************************
	typedef enum logic [1:0] {
		ST_LOAD = 2'b01,
		ST_RUN  = 2'b10
	} ivm_fsm_t;

	typedef struct packed {
		logic [7:0]  code;
		logic [15:0] data;
		logic        wr;
		logic        rd;
	} ivm_cmd_t;

	typedef struct packed {
		logic ov_warn;
		logic uv_warn;
		logic uv_fault;
		logic other;
		logic input_sum;
	} ivm_status_t;

	typedef struct packed {
		ivm_fsm_t    fsm;
		logic [15:0] ov_lim;
		logic [15:0] uvw_lim;
		logic [15:0] uvf_lim;
		ivm_status_t status;
		logic        uv_active;
		logic        notify;
		logic [15:0] rd_data;
		logic        rd_valid;
		logic        rd_err;
		logic        wr_refused;
	} ivm_state_t;

	localparam ivm_state_t STATE_RESET = '{
		fsm:        ST_LOAD,
		ov_lim:     OV_WARN_RESET,
		uvw_lim:    16'h0000,
		uvf_lim:    16'h0000,
		status:     5'h00,
		uv_active:  1'b0,
		notify:     1'b0,
		rd_data:    16'h0000,
		rd_valid:   1'b0,
		rd_err:     1'b0,
		wr_refused: 1'b0
	};

endpackage : ivm_pkg

// ==== src/ivm_lin_cmp.sv ====
`timescale 1ns/1ps
module ivm_lin_cmp
(
	input  wire logic [15:0] a,
	input  wire logic [15:0] b,
	output logic             gt,
	output logic             lt
);
	import ivm_pkg::*;

	// ************************************************
	// Word to fixed point
	// ************************************************
	// Mantissa times power of two
	function automatic logic signed [LIN_FIX_W-1:0] to_fix(input logic [15:0] w);
		logic [5:0]                  sh;
		logic signed [LIN_FIX_W-1:0] man;
		sh  = 6'({w[LIN_EXP_MSB], w[LIN_EXP_MSB:LIN_EXP_LSB]}) + LIN_FRAC_SHIFT;
		man = {{(LIN_FIX_W-LIN_MAN_MSB-1){w[LIN_MAN_MSB]}}, w[LIN_MAN_MSB:0]};
		return man <<< sh;
	endfunction : to_fix

	always_comb
	begin
		gt = to_fix(a) > to_fix(b);
		lt = to_fix(a) < to_fix(b);
	end

endmodule : ivm_lin_cmp

// ==== src/ivm_strap.sv ====
`timescale 1ns/1ps
module ivm_strap
#(
	parameter logic [4:0]  UNDERVOLTAGE_LOCKOUT_STRAP_EXP  = 5'h1c,
	parameter logic [43:0] UNDERVOLTAGE_LOCKOUT_STRAP_MANT = {11'h080, 11'h070, 11'h060, 11'h048}
)
(
	input  wire logic [1:0]  strap,
	output logic      [15:0] fault_def,
	output logic      [15:0] warn_def
);
	import ivm_pkg::*;

	logic [10:0] mant;
	logic [21:0] prod;

	// ************************************************
	// Strap defaults
	// ************************************************
	always_comb
	begin
		mant = UNDERVOLTAGE_LOCKOUT_STRAP_MANT[11*strap +: 11];
		prod = (22'(mant) * WARN_NUM) / WARN_DEN;
		fault_def = {UNDERVOLTAGE_LOCKOUT_STRAP_EXP, mant};
		warn_def = {UNDERVOLTAGE_LOCKOUT_STRAP_EXP, prod[10:0]};
	end

endmodule : ivm_strap

// ==== test/ivm_host_model.sv ====
`timescale 1ns/1ps
module ivm_host_model
(
	input  wire logic              clk,
	output ivm_pkg::ivm_cmd_t      cmd,
	input  wire logic [15:0]       rd_data,
	input  wire logic              rd_valid,
	input  wire logic              rd_err,
	input  wire logic              wr_refused
);
	import ivm_pkg::*;

	initial cmd = '0;

	// ************************************************
	// One command, answered one cycle after it is driven
	// ************************************************
	// Linear words whole
	task automatic xfer(input logic [7:0] code, input logic [15:0] data, input logic wr,
		input logic rd, output logic [15:0] q, output logic [2:0] flags);
		@(posedge clk);
		cmd <= '{code: code, data: data, wr: wr, rd: rd};
		@(posedge clk);
		cmd <= '{code: code, data: data, wr: 1'b0, rd: 1'b0};
		#1;
		q = rd_data;
		flags = {rd_valid, rd_err, wr_refused};
	endtask : xfer

endmodule : ivm_host_model

// ==== test/tb_ivm_input_voltage_limit_monitor.sv ====
`timescale 1ns/1ps
module tb_ivm_input_voltage_limit_monitor;
	import ivm_pkg::*;

	localparam logic [7:0] CLR = 8'h03;

	logic           clk_sys = 1'b0;
	logic           resetn = 1'b0;
	logic           write_protect = 1'b0;
	logic [15:0]    vin = 16'he090;
	logic [1:0]     undervoltage_lockout_strap_strap = 2'h0;
	ivm_cmd_t       cmd;
	logic [15:0]    rd_data;
	logic           rd_valid;
	logic           rd_err;
	logic           wr_refused;
	ivm_status_t    status;
	logic           uv_fault_active;
	logic           host_notify;
	int             mismatches = 0;
	int             checks = 0;
	logic [15:0]    q;
	logic [2:0]     f;
	logic [10:0]    mant [4] = '{11'h048, 11'h060, 11'h070, 11'h080};

	always #10 clk_sys = ~clk_sys;

	ivm_input_voltage_limit_monitor #(.CLEAR_CMD(CLR)) i_ivm_input_voltage_limit_monitor
	(
		.CLK_SYS         (clk_sys),
		.RESETN          (resetn),
		.CE              (1'b1),
		.CMD             (cmd),
		.WRITE_PROTECT   (write_protect),
		.VIN             (vin),
		.UNDERVOLTAGE_LOCKOUT_STRAP_STRAP      (undervoltage_lockout_strap_strap),
		.RD_DATA         (rd_data),
		.RD_VALID        (rd_valid),
		.RD_ERR          (rd_err),
		.WR_REFUSED      (wr_refused),
		.STATUS          (status),
		.UV_FAULT_ACTIVE (uv_fault_active),
		.HOST_NOTIFY     (host_notify)
	);

	ivm_host_model i_ivm_host_model
	(
		.clk        (clk_sys),
		.cmd        (cmd),
		.rd_data    (rd_data),
		.rd_valid   (rd_valid),
		.rd_err     (rd_err),
		.wr_refused (wr_refused)
	);

	// ************************************************
	// Helpers
	// ************************************************
	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
			mismatches++;
		end
	endtask : chk

	task automatic do_reset(input logic [1:0] strap);
		@(posedge clk_sys);
		resetn <= 1'b0;
		undervoltage_lockout_strap_strap <= strap;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (5) @(posedge clk_sys);
	endtask : do_reset

	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		i_ivm_host_model.xfer(code, 16'h0000, 1'b0, 1'b1, q, f);
		chk(q, exp);
		chk({13'h0000, f}, 16'h0004);
	endtask : rd

	task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic refused);
		i_ivm_host_model.xfer(code, data, 1'b1, 1'b0, q, f);
		chk({13'h0000, f}, {15'h0000, refused});
	endtask : wr

	// Exp packs {status, fault active, notify}
	task automatic vstep(input logic [15:0] v, input logic [6:0] exp);
		@(posedge clk_sys);
		vin <= v;
		@(posedge clk_sys);
		#1;
		chk({9'h000, status, uv_fault_active, host_notify}, {9'h000, exp});
	endtask : vstep

	initial
	begin
		repeat (5000) @(posedge clk_sys);
		mismatches++;
		end_sim();
	end

	// ************************************************
	// Main sequence
	// ************************************************
	initial
	begin
		for (int s = 0; s < 4; s++)
		begin
			do_reset(2'(s));
			rd(CMD_OV_WARN, OV_WARN_RESET);
			rd(CMD_UV_WARN, {5'h1c, 11'(mant[s] * 11 / 10)});
			rd(CMD_UV_FAULT, {5'h1c, mant[s]});
		end
		wr(CMD_OV_WARN, 16'h0013, 1'b0);
		rd(CMD_OV_WARN, 16'h0013);
		wr(CMD_OV_WARN, 16'h0014, 1'b1);
		wr(CMD_OV_WARN, 16'he0a0, 1'b0);
		rd(CMD_OV_WARN, 16'he0a0);
		wr(CMD_UV_FAULT, 16'h07ff, 1'b1);
		wr(CMD_UV_FAULT, 16'h0014, 1'b1);
		wr(CMD_UV_FAULT, 16'he070, 1'b0);
		rd(CMD_UV_FAULT, 16'he070);
		i_ivm_host_model.xfer(8'h5a, 16'h0000, 1'b0, 1'b1, q, f);
		chk({13'h0000, f}, 16'h0002);
		wr(8'h5a, 16'h0001, 1'b1);
		@(posedge clk_sys);
		write_protect <= 1'b1;
		wr(CMD_UV_WARN, 16'he080, 1'b1);
		rd(CMD_UV_WARN, 16'he08c);
		@(posedge clk_sys);
		write_protect <= 1'b0;
		wr(CMD_UV_WARN, 16'h0008, 1'b0);
		rd(CMD_UV_WARN, 16'h0008);
		wr(CMD_UV_WARN, 16'he08c, 1'b0);
		wr(CLR, 16'h0000, 1'b0);
		vstep(16'he090, 7'h00);
		vstep(16'h000b, 7'h4d);
		wr(CLR, 16'h0000, 1'b0);
		vstep(16'h000b, 7'h4d);
		vstep(16'he090, 7'h4d);
		wr(CLR, 16'h0000, 1'b0);
		vstep(16'he090, 7'h00);
		vstep(16'he088, 7'h2d);
		vstep(16'he068, 7'h3f);
		vstep(16'he088, 7'h3f);
		vstep(16'he090, 7'h3d);
		wr(CLR, 16'h0000, 1'b0);
		vstep(16'he090, 7'h00);
		end_sim();
	end

endmodule : tb_ivm_input_voltage_limit_monitor
